//--- include/rwi_map.vh
// Register offsets, field positions, reset values and codes of the reset and wake-up block.
`ifndef RWI_MAP_VH
`define RWI_MAP_VH
`define RWI_OFF_PORT_A_DIR 8'h00
`define RWI_OFF_PORT_A_LAT 8'h04
`define RWI_OFF_PORT_A_PIN 8'h08
`define RWI_OFF_CTRL 8'h0c
`define RWI_OFF_PC 8'h10
`define RWI_OFF_TOS 8'h14
`define RWI_OFF_RETURN_STACK_POINTER 8'h18
`define RWI_OFF_WAKE_FLAGS 8'h1c
`define RWI_OFF_IRQ_STATUS 8'h20
`define RWI_OFF_IRQ_MASK 8'h24
`define RWI_OFF_RESET_CAUSE 8'h28
`define RWI_PORT_A_BIT6 6
`define RWI_DIR_RESET 8'hff
`define RWI_LAT_RESET 8'h00
`define RWI_CTRL_HIGH_PRIO_GLOBAL_IRQ_EN 0
`define RWI_CTRL_LOW_PRIO_GLOBAL_IRQ_EN 1
`define RWI_CTRL_LWE 2
`define RWI_CTRL_OSC_LSB 4
`define RWI_CTRL_OSC_W 3
`define RWI_CTRL_SLEEP 7
`define RWI_CTRL_MASK 8'hf7
`define RWI_OSC_EXT_CLOCK_IO_OSC_MODE 3'h5
`define RWI_OSC_RESISTOR_CAP_IO_OSC_MODE 3'h6
`define RWI_VEC_HIGH 21'h000008
`define RWI_VEC_LOW 21'h000018
`define RWI_PC_W 21
`define RWI_SP_W 5
`define RWI_SP_MAX 5'h1f
`define RWI_RST_POR 3'h0
`define RWI_RST_BOR 3'h1
`define RWI_RST_PIN 3'h2
`define RWI_RST_WDT 3'h3
`define RWI_RST_INSTR 3'h4
`define RWI_RST_STACK 3'h5
`define RWI_ST_RESET 0
`define RWI_ST_WAKE_WDT 1
`define RWI_ST_WAKE_IRQ 2
`define RWI_ST_PUSH_FULL 3
`endif

//--- src/rwi_port_bit6.v
// Port A bit 6 gating by oscillator mode and device variant.
`timescale 1ns/10ps
`default_nettype none
`include "rwi_map.vh"
module rwi_port_bit6 (
  input wire bit6_present_i,
  input wire [2:0] osc_mode_i,
  output wire bit6_enable_o
);
  assign bit6_enable_o = bit6_present_i &&
    ((osc_mode_i == `RWI_OSC_EXT_CLOCK_IO_OSC_MODE) || (osc_mode_i == `RWI_OSC_RESISTOR_CAP_IO_OSC_MODE));
endmodule
`default_nettype wire

//--- src/rwi_stack.v
// Return address stack of 31 words with a top-of-stack write port.
`timescale 1ns/10ps
`default_nettype none
`include "rwi_map.vh"
module rwi_stack (
  input wire clk_i,
  input wire [4:0] ptr_i,
  input wire wr_i,
  input wire [20:0] wdata_i,
  output wire [20:0] rdata_o
);
  reg [20:0] mem [1:31];
  always @(posedge clk_i) begin
    if (wr_i && ptr_i != 5'h00) begin
      mem[ptr_i] <= wdata_i;
    end
  end
  // Pointer zero has no storage and reads as zero.
  assign rdata_o = (ptr_i == 5'h00) ? 21'h000000 : mem[ptr_i];
endmodule
`default_nettype wire

//--- src/rwi_top.v
// Reset classes, wake-up redirection and port A gating with an AHB-Lite register slave.
//
// Overview of operation
// - Interrupt wake with global enable loads vector.
// - That wake pushes program counter onto stack.
// - Watchdog or interrupt wake sets cause flags.
// - Port A bit 6 only in two modes.
// - Absent port A bit 6 reads zero.
// - Long write enable cleared by power-on, pin only.
// - Unimplemented bits read zero, ignore writes.
// - Each register but the interrupt mask (rst_n_i only) and the interrupt status (a class ORs its event in) initialises per reset class.
`timescale 1ns/10ps
`default_nettype none
`include "rwi_map.vh"
module rwi_top (
  input wire clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  input wire reset_req_i,
  input wire [2:0] reset_class_i,
  input wire wake_wdt_i,
  input wire wake_irq_i,
  input wire wake_irq_high_i,
  input wire [7:0] wake_irq_src_i,
  input wire bit6_present_i,
  input wire [7:0] port_a_pins_i,
  output reg [7:0] port_a_latch_o,
  output reg [7:0] port_a_direction_o,
  output reg [20:0] pc_o,
  output reg irq_o
);
  localparam ST_RUN = 2'd0;
  localparam ST_PUSH = 2'd1;
  localparam ST_VECTOR = 2'd2;

  reg [1:0] state;
  reg [7:0] port_a_direction;
  reg [7:0] port_a_latch;
  reg [7:0] ctrl;
  reg [20:0] pc;
  reg [4:0] return_stack_pointer;
  reg stk_full;
  reg [7:0] wake_flags;
  reg [3:0] irq_status;
  reg [3:0] irq_mask;
  reg [2:0] last_reset;
  reg [20:0] vector;
  reg ap_valid;
  reg ap_write;
  reg [7:0] ap_addr;
  reg stk_wr;
  reg [20:0] stk_wdata;
  reg [7:0] rd_word;
  reg [31:0] rd_mux;
  reg [3:0] next_events;
  wire [20:0] stack_top;
  wire bit6_enable;
  wire [7:0] bit6_gate;
  wire hw_wr;
  wire wake_irq_go;
  wire rd_take;
  wire [3:0] irq_pend;

  rwi_port_bit6 u_bit6 (
    .bit6_present_i(bit6_present_i),
    .osc_mode_i(ctrl[`RWI_CTRL_OSC_LSB +: `RWI_CTRL_OSC_W]),
    .bit6_enable_o(bit6_enable)
  );

  // The push writes the word at the pointer advanced one cycle earlier.
  rwi_stack u_stack (
    .clk_i(clk_i),
    .ptr_i(return_stack_pointer),
    .wr_i(stk_wr),
    .wdata_i(stk_wdata),
    .rdata_o(stack_top)
  );

  // Bit 6 of the port A registers is forced to zero unless enabled.
  assign bit6_gate = bit6_enable ? 8'hff : 8'hbf;
  assign hw_wr = ap_valid && ap_write;
  assign rd_take = hready_i && hsel_i && htrans_i[1] && !hwrite_i;
  // An interrupt only redirects when a global enable is set during sleep.
  assign wake_irq_go = ctrl[`RWI_CTRL_SLEEP] && wake_irq_i &&
    (ctrl[`RWI_CTRL_HIGH_PRIO_GLOBAL_IRQ_EN] || ctrl[`RWI_CTRL_LOW_PRIO_GLOBAL_IRQ_EN]);

  function is_class;
    input [2:0] cls;
    input [2:0] want;
    begin
      is_class = (cls == want);
    end
  endfunction

  function addr_is;
    input [7:0] addr;
    input [7:0] off;
    begin
      addr_is = (addr == off);
    end
  endfunction

  // One pending term per status bit; the interrupt output ORs them.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pend
      assign irq_pend[gi] = irq_status[gi] & irq_mask[gi];
    end
  endgenerate

  // AHB-Lite address phase capture; zero wait states, always OKAY.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr <= 8'h00;
    end else if (hready_i) begin
      ap_valid <= hsel_i && htrans_i[1];
      ap_write <= hwrite_i;
      ap_addr <= haddr_i[7:0];
    end
  end

  // Read data comes from the address phase and is registered for the data phase.
  always @* begin
    rd_word = 8'h00;
    rd_mux = 32'h00000000;
    case (haddr_i[7:0])
      `RWI_OFF_PORT_A_DIR: rd_mux = {24'h000000, port_a_direction & bit6_gate};
      `RWI_OFF_PORT_A_LAT: rd_mux = {24'h000000, port_a_latch & bit6_gate};
      `RWI_OFF_PORT_A_PIN: rd_mux = {24'h000000, port_a_pins_i & bit6_gate};
      `RWI_OFF_CTRL: rd_mux = {24'h000000, ctrl & `RWI_CTRL_MASK};
      `RWI_OFF_PC: rd_mux = {11'h000, pc};
      `RWI_OFF_TOS: rd_mux = {11'h000, stack_top};
      `RWI_OFF_RETURN_STACK_POINTER: begin
        rd_word = {stk_full, 2'b00, return_stack_pointer};
        rd_mux = {24'h000000, rd_word};
      end
      `RWI_OFF_WAKE_FLAGS: rd_mux = {24'h000000, wake_flags};
      `RWI_OFF_IRQ_STATUS: rd_mux = {28'h0000000, irq_status};
      `RWI_OFF_IRQ_MASK: rd_mux = {28'h0000000, irq_mask};
      `RWI_OFF_RESET_CAUSE: rd_mux = {29'h00000000, last_reset};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      // A read right after a write to the same word still returns the old value.
      if (rd_take) begin
        hrdata_o <= rd_mux;
      end
    end
  end

  // Stack write for the push of an interrupt wake or a bus write to the top-of-stack register.
  always @* begin
    stk_wr = 1'b0;
    stk_wdata = pc;
    if (state == ST_PUSH) begin
      stk_wr = 1'b1;
    end else if (hw_wr && addr_is(ap_addr, `RWI_OFF_TOS)) begin
      stk_wr = 1'b1;
      stk_wdata = hwdata_i[20:0];
    end
  end

  // Event strobes that set the sticky status bits.
  always @* begin
    next_events = 4'h0;
    next_events[`RWI_ST_RESET] = reset_req_i;
    next_events[`RWI_ST_WAKE_WDT] = ctrl[`RWI_CTRL_SLEEP] && wake_wdt_i;
    next_events[`RWI_ST_WAKE_IRQ] = wake_irq_go;
    next_events[`RWI_ST_PUSH_FULL] = (state == ST_PUSH) &&
      (return_stack_pointer == `RWI_SP_MAX);
  end

  // Power-on state; the synchronous classes below reload only part of it, per class.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_RUN;
      ctrl <= 8'h00;
      port_a_direction <= `RWI_DIR_RESET;
      port_a_latch <= `RWI_LAT_RESET;
      pc <= 21'h000000;
      return_stack_pointer <= 5'h00;
      stk_full <= 1'b0;
      wake_flags <= 8'h00;
      irq_status <= 4'h0;
      irq_mask <= 4'h0;
      last_reset <= `RWI_RST_POR;
      vector <= 21'h000000;
    end else if (reset_req_i) begin
      // Synchronous reset classes; wake-ups never come through here.
      state <= ST_RUN;
      last_reset <= reset_class_i;
      pc <= 21'h000000;
      return_stack_pointer <= 5'h00;
      ctrl[`RWI_CTRL_SLEEP] <= 1'b0;
      ctrl[`RWI_CTRL_HIGH_PRIO_GLOBAL_IRQ_EN] <= 1'b0;
      ctrl[`RWI_CTRL_LOW_PRIO_GLOBAL_IRQ_EN] <= 1'b0;
      wake_flags <= 8'h00;
      irq_status <= irq_status | next_events;
      if (is_class(reset_class_i, `RWI_RST_POR) || is_class(reset_class_i, `RWI_RST_PIN)) begin
        ctrl[`RWI_CTRL_LWE] <= 1'b0;
      end
      if (is_class(reset_class_i, `RWI_RST_POR) || is_class(reset_class_i, `RWI_RST_BOR)) begin
        ctrl[`RWI_CTRL_OSC_LSB +: `RWI_CTRL_OSC_W] <= 3'h0;
        stk_full <= 1'b0;
      end
      port_a_direction <= `RWI_DIR_RESET;
      // The latch is kept over pin and software resets.
      if (is_class(reset_class_i, `RWI_RST_POR) || is_class(reset_class_i, `RWI_RST_BOR)) begin
        port_a_latch <= `RWI_LAT_RESET;
      end
    end else begin
      case (state)
        ST_RUN: begin
          if (wake_irq_go) begin
            ctrl[`RWI_CTRL_SLEEP] <= 1'b0;
            wake_flags <= wake_flags | wake_irq_src_i;
            vector <= wake_irq_high_i ? `RWI_VEC_HIGH : `RWI_VEC_LOW;
            if (return_stack_pointer != `RWI_SP_MAX) begin
              return_stack_pointer <= return_stack_pointer + 5'h01;
            end
            state <= ST_PUSH;
          end else if (ctrl[`RWI_CTRL_SLEEP] && (wake_wdt_i || wake_irq_i)) begin
            // Watchdog wake, or interrupt wake with no global enable set, resumes in line; contents retained.
            ctrl[`RWI_CTRL_SLEEP] <= 1'b0;
            wake_flags <= wake_flags | wake_irq_src_i | {7'h00, wake_wdt_i};
            pc <= pc + 21'h000002;
          end
        end
        ST_PUSH: begin
          // At the last level the newest push overwrites the top word.
          if (return_stack_pointer == `RWI_SP_MAX) begin
            stk_full <= 1'b1;
          end
          state <= ST_VECTOR;
        end
        ST_VECTOR: begin
          pc <= vector;
          state <= ST_RUN;
        end
        default: state <= ST_RUN;
      endcase
      // A new event in the same cycle as its write-one clear stays set.
      irq_status <= (irq_status | next_events) &
        ~((hw_wr && addr_is(ap_addr, `RWI_OFF_IRQ_STATUS)) ?
        (hwdata_i[3:0] & ~next_events) : 4'h0);
      if (hw_wr) begin
        case (ap_addr)
          `RWI_OFF_PORT_A_DIR: port_a_direction <= hwdata_i[7:0] & bit6_gate;
          `RWI_OFF_PORT_A_LAT: port_a_latch <= hwdata_i[7:0] & bit6_gate;
          `RWI_OFF_CTRL: ctrl <= (hwdata_i[7:0] & `RWI_CTRL_MASK);
          `RWI_OFF_PC: pc <= hwdata_i[20:0];
          `RWI_OFF_RETURN_STACK_POINTER: begin
            return_stack_pointer <= hwdata_i[4:0];
            if (!hwdata_i[7]) begin
              stk_full <= 1'b0;
            end
          end
          `RWI_OFF_WAKE_FLAGS: wake_flags <= hwdata_i[7:0];
          `RWI_OFF_IRQ_MASK: irq_mask <= hwdata_i[3:0];
          default: irq_mask <= irq_mask;
        endcase
      end
    end
  end

  // Registered copies of the pin-facing values and the interrupt line.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_a_latch_o <= `RWI_LAT_RESET;
      port_a_direction_o <= `RWI_DIR_RESET;
      pc_o <= 21'h000000;
      irq_o <= 1'b0;
    end else begin
      port_a_latch_o <= port_a_latch & bit6_gate;
      port_a_direction_o <= port_a_direction | ~bit6_gate;
      pc_o <= pc;
      irq_o <= |irq_pend;
    end
  end
endmodule
`default_nettype wire

//--- bench/rwi_top_props.sv
// Port-level checks of the reset and wake-up block.
`timescale 1ns/10ps
`default_nettype none
`include "rwi_map.vh"
module rwi_top_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic reset_req_i,
  input wire logic [2:0] reset_class_i,
  input wire logic wake_irq_i,
  input wire logic wake_irq_high_i,
  input wire logic bit6_present_i,
  input wire logic [7:0] port_a_latch_o,
  input wire logic [7:0] port_a_direction_o,
  input wire logic [20:0] pc_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_bus_ok; hreadyout_o && !hresp_o; endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("slave not ready or not okay");
  property p_pc_clear; reset_req_i |=> ##1 pc_o == 21'h0; endproperty
  a_pc_clear: assert property (p_pc_clear) else $error("pc kept over reset");
  property p_dir_ones;
    reset_req_i |=> ##1 port_a_direction_o == `RWI_DIR_RESET;
  endproperty
  a_dir_ones: assert property (p_dir_ones) else $error("direction not all ones");
  property p_lat_clr;
    reset_req_i && reset_class_i < 3'h2 |=> ##1 port_a_latch_o == 8'h0;
  endproperty
  a_lat_clr: assert property (p_lat_clr) else $error("latch not cleared");
  property p_lat_keep;
    reset_req_i && reset_class_i > 3'h1 |=> ##1 $stable(port_a_latch_o);
  endproperty
  a_lat_keep: assert property (p_lat_keep) else $error("latch lost on reset");
  property p_bit6_off; !bit6_present_i [*2] |-> !port_a_latch_o[6]; endproperty
  a_bit6_off: assert property (p_bit6_off) else $error("absent bit 6 driven");
  property p_vec_hi;
    $changed(pc_o) && pc_o == `RWI_VEC_HIGH |-> $past(wake_irq_i, 4) && $past(wake_irq_high_i, 4);
  endproperty
  a_vec_hi: assert property (p_vec_hi) else $error("high vector without wake");
  property p_vec_lo;
    $changed(pc_o) && pc_o == `RWI_VEC_LOW |-> $past(wake_irq_i, 4) && !$past(wake_irq_high_i, 4);
  endproperty
  a_vec_lo: assert property (p_vec_lo) else $error("low vector without wake");
endmodule
bind rwi_top rwi_top_props u_props (.*);
`default_nettype wire

//--- bench/test_reset_and_wakeup_init.sv
// Self-checking bench for the reset and wake-up block.
`timescale 1ns/10ps
`default_nettype none
`include "rwi_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_reset_and_wakeup_init;
  logic clk_i = 0, rst_n_i = 0, hsel_i = 1, hwrite_i = 0, reset_req_i = 0, rd_pend = 0;
  logic wake_wdt_i = 0, wake_irq_i = 0, wake_irq_high_i = 0, bit6_present_i = 1;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, exp_w;
  logic [1:0] htrans_i = 0;
  logic [2:0] hsize_i = 3'h2, reset_class_i = 0;
  logic [7:0] wake_irq_src_i = 0, port_a_pins_i = 0, port_a_latch_o, port_a_direction_o;
  logic [20:0] pc_o;
  logic hreadyout_o, hresp_o, irq_o;
  logic [31:0] q[$];
  int n_mismatch = 0, checked = 0;
  rwi_top uut (.hready_i(hreadyout_o), .*);
  initial forever #20 clk_i = ~clk_i;
  always @(posedge clk_i) if (rd_pend && hreadyout_o) begin
    exp_w = q.pop_front();
    `CHK(hrdata_o, exp_w)
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A read passes its expected word in d.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    @(posedge clk_i);
    while (!hreadyout_o) @(posedge clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= w ? d : 32'h0;
    rd_pend <= !w;
    if (!w) q.push_back(d);
    @(posedge clk_i);
    while (!hreadyout_o) @(posedge clk_i);
    rd_pend <= 0;
  endtask
  task automatic rreq(input logic [2:0] c);
    reset_req_i <= 1;
    reset_class_i <= c;
    @(posedge clk_i);
    reset_req_i <= 0;
    @(posedge clk_i);
  endtask
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    logic en;
    logic [7:0] m;
    void'($urandom(32'h7d0d));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1;
    @(posedge clk_i);
    xfer(0, `RWI_OFF_PORT_A_DIR, 32'hbf);
    xfer(0, `RWI_OFF_PC, 32'h0);
    xfer(1, `RWI_OFF_CTRL, $urandom | 32'hff);
    xfer(0, `RWI_OFF_CTRL, {24'h0, `RWI_CTRL_MASK});
    xfer(1, 8'h3c, $urandom);
    xfer(0, 8'h3c, 32'h0);
    for (int i = 0; i < 16; i++) begin
      bit6_present_i <= i[3];
      port_a_pins_i <= 8'($urandom);
      en = i[3] && (i[2:0] == `RWI_OSC_EXT_CLOCK_IO_OSC_MODE || i[2:0] == `RWI_OSC_RESISTOR_CAP_IO_OSC_MODE);
      m = en ? 8'hff : 8'hbf;
      xfer(1, `RWI_OFF_CTRL, {25'h0, i[2:0], 4'h0});
      xfer(1, `RWI_OFF_PORT_A_DIR, 32'hff);
      xfer(0, `RWI_OFF_PORT_A_DIR, {24'h0, m});
      xfer(1, `RWI_OFF_PORT_A_LAT, 32'hff);
      xfer(0, `RWI_OFF_PORT_A_LAT, {24'h0, m});
      xfer(0, `RWI_OFF_PORT_A_PIN, {24'h0, port_a_pins_i & m});
      `CHK(port_a_latch_o, m)
    end
    for (int c = 0; c < 6; c++) begin
      xfer(1, `RWI_OFF_CTRL, 32'h57);
      xfer(1, `RWI_OFF_PORT_A_LAT, 32'h5a);
      xfer(1, `RWI_OFF_PORT_A_DIR, 32'h0);
      xfer(1, `RWI_OFF_IRQ_STATUS, 32'hf);
      rreq(c[2:0]);
      xfer(0, `RWI_OFF_CTRL, ((c == 0 || c == 2) ? 32'h0 : 32'h4) | (c < 2 ? 32'h0 : 32'h50));
      xfer(0, `RWI_OFF_PORT_A_LAT, c < 2 ? 32'h0 : 32'h5a);
      xfer(0, `RWI_OFF_PORT_A_DIR, c < 2 ? 32'hbf : 32'hff);
      xfer(0, `RWI_OFF_IRQ_STATUS, 32'h1);
    end
    for (int k = 0; k < 3; k++) begin
      rreq(3'h4);
      xfer(1, `RWI_OFF_IRQ_STATUS, 32'hf);
      xfer(1, `RWI_OFF_IRQ_MASK, 32'h6);
      xfer(1, `RWI_OFF_PC, 32'h100);
      xfer(1, `RWI_OFF_CTRL, k < 2 ? 32'h83 : 32'h80);
      m = 8'($urandom);
      wake_irq_src_i <= m;
      wake_irq_high_i <= k == 0;
      wake_irq_i <= k < 2;
      wake_wdt_i <= k == 2;
      @(posedge clk_i);
      wake_irq_i <= 0;
      wake_wdt_i <= 0;
      repeat (4) @(posedge clk_i);
      xfer(0, `RWI_OFF_PC, k == 2 ? 32'h102 : {11'h0, k ? `RWI_VEC_LOW : `RWI_VEC_HIGH});
      xfer(0, `RWI_OFF_RETURN_STACK_POINTER, k < 2 ? 32'h1 : 32'h0);
      if (k < 2) xfer(0, `RWI_OFF_TOS, 32'h100);
      if (k < 2) xfer(0, `RWI_OFF_WAKE_FLAGS, {24'h0, m});
      xfer(0, `RWI_OFF_IRQ_STATUS, k < 2 ? 32'h4 : 32'h2);
      `CHK(irq_o, 1'b1)
      xfer(1, `RWI_OFF_IRQ_MASK, 32'h0);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
      xfer(1, `RWI_OFF_IRQ_MASK, 32'h6);
      xfer(1, `RWI_OFF_IRQ_STATUS, 32'h6);
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, 1'b0)
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
